// ### inc/squib_pkg.sv
// Overview of operation
// - A0 arms 1A/1B, A1 2A/2B, A2 all
// - Fire bits 0..3 drive 1A, 1B, 2A, 2B
// - Fire nibble 5 must follow arm nibble A
// - Parity mismatch discards data, drivers unchanged
// - Accepted arm byte pulses the diagnostic clear output
// - Fire byte sets any on/off combination
// - Driver stops only on sequence, reset, thermal, enable
// - Count current above threshold during measurement window
// - Fire-enable low stops drivers unless latch-and-hold
// - Fire-enable returning high resumes commanded drivers
// - Enable one gates 1A/1B, enable two 2A/2B
// - Arm and fire bytes echo on next transfer
// - Intervening byte turns fire byte into no-op
package squib_pkg;

	// Command encodings.
	localparam logic [7:0] ARM_GROUP_ONE = 8'ha0;
	localparam logic [7:0] ARM_GROUP_TWO = 8'ha1;
	localparam logic [7:0] ARM_ALL = 8'ha2;
	localparam logic [3:0] ARM_NIBBLE = 4'ha;
	localparam logic [3:0] FIRE_NIBBLE = 4'h5;

	// Channel masks: bit 0 is 1A, bit 1 is 1B, bit 2 is 2A, bit 3 is 2B.
	localparam logic [3:0] GROUP_ONE_MASK = 4'h3;
	localparam logic [3:0] GROUP_TWO_MASK = 4'hc;
	localparam int CHANNELS = 4;
	localparam int COUNT_WIDTH = 8;
	localparam int TIMER_WIDTH = 24;

	// Timing, in nanoseconds, and the derived cycle counts.
	localparam int CLK_PERIOD_NS = 10;
	localparam int MIN_FIRE_TIME_NS = 500000;
	localparam int MEAS_WINDOW_TIME_NS = 1000000;
	localparam int MIN_FIRE_CYCLES = (MIN_FIRE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MEAS_WINDOW_CYCLES = MEAS_WINDOW_TIME_NS / CLK_PERIOD_NS;

	// Register map, byte addresses.
	localparam logic [3:0] CONTROL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam logic [3:0] COUNTS_OFFSET = 4'h8;

	// Control fields.
	localparam int CTRL_HOLD_ONE_BIT = 0;
	localparam int CTRL_HOLD_TWO_BIT = 1;
	localparam int CTRL_COUNT_CLEAR_BIT = 2;
	localparam logic [1:0] CONTROL_RESET = 2'h0;

	// Status fields.
	localparam int STAT_COMMAND_LSB = 0;
	localparam int STAT_DRIVER_LSB = 4;
	localparam int STAT_ARMED_LSB = 8;
	localparam int STAT_THERMAL_LSB = 12;
	localparam int STAT_ENABLE_LSB = 16;
	localparam int STAT_LATCH_LSB = 18;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : squib_pkg

// ### core/squib_channel_counter.sv
`timescale 1ns/1ps
// One channel's firing timer and current-limit measurement counter.
module squib_channel_counter #(
	parameter int MIN_CYCLES = 50000,
	parameter int WINDOW_CYCLES = 100000,
	parameter int TIMER_W = 24,
	parameter int COUNT_W = 8
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Channel activity.
	input wire logic firing_i,
	input wire logic restart_i,
	input wire logic over_threshold_i,
	input wire logic clear_i,
	// Results.
	output logic min_done_o,
	output logic [COUNT_W-1:0] count_o
);
	localparam int LIMIT = (MIN_CYCLES > WINDOW_CYCLES) ? MIN_CYCLES : WINDOW_CYCLES;

	// The timer must be able to reach both the minimum firing time and the window.
	initial begin
		if (LIMIT >= (1 << TIMER_W) || MIN_CYCLES < 1 || WINDOW_CYCLES < 1)
			$error("squib_channel_counter: timer too narrow for the chosen counts");
	end

	logic [TIMER_W-1:0] timer; // Cycles spent firing since the command began.
	logic measure_active; // High while the measurement window is open.

	assign measure_active = firing_i && (timer < TIMER_W'(WINDOW_CYCLES));
	assign min_done_o = (timer >= TIMER_W'(MIN_CYCLES));

	// The timer saturates so that a long burn never wraps back into the window.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			timer <= '0;
		end else if (restart_i) begin
			timer <= '0;
		end else if (firing_i && timer < TIMER_W'(LIMIT)) begin
			timer <= timer + 1'b1;
		end
	end

	// The measurement counter saturates at all ones rather than wrapping.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_o <= '0;
		end else if (clear_i || restart_i) begin
			count_o <= '0;
		end else if (measure_active && over_threshold_i && count_o != '1) begin
			count_o <= count_o + 1'b1;
		end
	end

endmodule : squib_channel_counter

// ### core/squib_arm_fire_sequencer.sv
`timescale 1ns/1ps
// Arm-then-fire command sequencer for four squib driver channels.
module squib_arm_fire_sequencer #(
	parameter int MIN_FIRE_CYCLES = squib_pkg::MIN_FIRE_CYCLES,
	parameter int MEAS_WINDOW_CYCLES = squib_pkg::MEAS_WINDOW_CYCLES
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Received bytes from the serial shifter, one pulse per full byte.
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_byte_i,
	// Byte to shift out on the next transfer.
	output logic [7:0] echo_byte_o,
	// Diagnostic clear pulse.
	output logic diag_clear_o,
	// Fire-enable pins and analog status.
	input wire logic fire_enable_pin_one_i,
	input wire logic fire_enable_pin_two_i,
	input wire logic [squib_pkg::CHANNELS-1:0] thermal_shutdown_i,
	input wire logic [squib_pkg::CHANNELS-1:0] current_measure_threshold_i,
	// Driver gates.
	output logic [squib_pkg::CHANNELS-1:0] driver_on_o,
	// AXI4-Lite write address.
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data.
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address.
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data.
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import squib_pkg::*;

	// Elaboration check on the timing parameters.
	initial begin
		if (MIN_FIRE_CYCLES < 1 || MEAS_WINDOW_CYCLES < 1)
			$error("squib_arm_fire_sequencer: timing counts must be at least one");
	end

	// Pin synchronisers: first stage is read only by the second stage.
	logic [9:0] pin_s1;
	logic [9:0] pin_s2;
	logic [9:0] pin_s3;
	logic [9:0] pin_filt; // Accepted levels, updated once stages two and three agree.
	logic [1:0] enable_level; // Bit 0 is enable one, bit 1 is enable two.
	logic [3:0] thermal_level;
	logic [3:0] over_level;

	// Sequencer state.
	logic [3:0] armed; // Channels armed by the previous byte.
	logic [3:0] fire_command; // Latched on/off command per channel.
	logic [3:0] thermal_trip; // Channel stopped by thermal shutdown.
	logic [1:0] latch_hold; // Latch-and-hold capture per group.
	logic [1:0] hold_enable; // Software enable of latch-and-hold per group.
	logic count_clear; // One-cycle clear of the measurement counters.
	logic [3:0] group_gate; // Per-channel enable after latch-and-hold.
	logic [3:0] min_done;
	logic [COUNT_WIDTH-1:0] counts [CHANNELS];

	// Decoded byte classes.
	logic is_arm_byte;
	logic is_fire_byte;
	logic [3:0] arm_mask;
	logic [3:0] next_command;
	logic fire_accept;

	// Three-stage synchronisers with an agree filter on the last two stages.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin_filt <= '0;
		end else begin
			pin_s1 <= {current_measure_threshold_i, thermal_shutdown_i,
				fire_enable_pin_two_i, fire_enable_pin_one_i};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_filt <= (pin_s2 & pin_s3) | (pin_filt & (pin_s2 | pin_s3));
		end
	end

	assign enable_level = pin_filt[1:0];
	assign thermal_level = pin_filt[5:2];
	assign over_level = pin_filt[9:6];

	// Arm decode; a group can only be armed while its enable pin is high.
	always_comb begin
		arm_mask = 4'h0;
		case (cmd_byte_i)
			ARM_GROUP_ONE: arm_mask = GROUP_ONE_MASK;
			ARM_GROUP_TWO: arm_mask = GROUP_TWO_MASK;
			ARM_ALL: arm_mask = GROUP_ONE_MASK | GROUP_TWO_MASK;
			default: arm_mask = 4'h0;
		endcase
		if (!enable_level[0])
			arm_mask = arm_mask & ~GROUP_ONE_MASK;
		if (!enable_level[1])
			arm_mask = arm_mask & ~GROUP_TWO_MASK;
	end

	assign is_arm_byte = (cmd_byte_i == ARM_GROUP_ONE) || (cmd_byte_i == ARM_GROUP_TWO)
		|| (cmd_byte_i == ARM_ALL);
	assign is_fire_byte = (cmd_byte_i[7:4] == FIRE_NIBBLE);

	// A fire byte counts only straight after an arm byte; a wrong upper
	// nibble or an empty arm leaves the drivers as they are.
	assign fire_accept = cmd_valid_i && is_fire_byte && (armed != 4'h0);

	// Armed channels take their data bit; other channels keep their command.
	assign next_command = (fire_command & ~armed) | (cmd_byte_i[3:0] & armed);

	// Arm state lives for exactly one following byte.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			armed <= 4'h0;
		end else if (cmd_valid_i) begin
			armed <= is_arm_byte ? arm_mask : 4'h0;
		end
	end

	// The fire command changes only on a complete valid sequence.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fire_command <= 4'h0;
		end else if (fire_accept) begin
			fire_command <= next_command;
		end
	end

	// Diagnostics are cleared by an accepted arm byte.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			diag_clear_o <= 1'b0;
		end else begin
			diag_clear_o <= cmd_valid_i && is_arm_byte && (arm_mask != 4'h0);
		end
	end

	// Arm and fire bytes are returned on the next transfer; others read zero
	// here because diagnostic results are produced elsewhere.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			echo_byte_o <= 8'h00;
		end else if (cmd_valid_i) begin
			echo_byte_o <= (is_arm_byte || is_fire_byte) ? cmd_byte_i : 8'h00;
		end
	end

	// Thermal shutdown stops a channel only after its minimum burn; the stop
	// holds until a new valid sequence, so a cooling die does not refire.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			thermal_trip <= 4'h0;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (thermal_level[i] && min_done[i] && driver_on_o[i])
					thermal_trip[i] <= 1'b1;
				else if (fire_accept && armed[i])
					thermal_trip[i] <= 1'b0;
			end
		end
	end

	// Latch-and-hold: once a group fires with hold enabled, a later drop of
	// its enable pin no longer stops it; released when the group is off.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			latch_hold <= 2'h0;
		end else begin
			for (int g = 0; g < 2; g++) begin
				if ((fire_command & (g == 0 ? GROUP_ONE_MASK : GROUP_TWO_MASK)) == 4'h0)
					latch_hold[g] <= 1'b0;
				else if (hold_enable[g] && enable_level[g])
					latch_hold[g] <= 1'b1;
			end
		end
	end

	// Group gates follow the pins, so a returning pin resumes the command.
	assign group_gate = {{2{enable_level[1] | latch_hold[1]}},
		{2{enable_level[0] | latch_hold[0]}}};

	// Driver outputs are registered from command, gate and thermal state.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			driver_on_o <= 4'h0;
		end else begin
			driver_on_o <= fire_command & group_gate & ~thermal_trip;
		end
	end

	// One timer and measurement counter per channel.
	for (genvar c = 0; c < CHANNELS; c++) begin : gen_channel
		squib_channel_counter #(
			.MIN_CYCLES(MIN_FIRE_CYCLES),
			.WINDOW_CYCLES(MEAS_WINDOW_CYCLES),
			.TIMER_W(TIMER_WIDTH),
			.COUNT_W(COUNT_WIDTH)
		) u_counter (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.firing_i(driver_on_o[c]),
			.restart_i(fire_accept && armed[c] && cmd_byte_i[c]),
			.over_threshold_i(over_level[c]),
			.clear_i(count_clear),
			.min_done_o(min_done[c]),
			.count_o(counts[c])
		);
	end

	// Bus slave: address and data are held until both have arrived.
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic write_go;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign write_go = aw_held && w_held && !s_axi_bvalid;

	// Capture the address and data channels independently.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (write_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (write_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// Perform the write and raise the response in the same edge.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_enable <= CONTROL_RESET;
			count_clear <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			count_clear <= 1'b0;
			if (write_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= RESP_OKAY;
				if (aw_addr == CONTROL_OFFSET) begin
					if (w_strb[0]) begin
						hold_enable <= {w_data[CTRL_HOLD_TWO_BIT], w_data[CTRL_HOLD_ONE_BIT]};
						count_clear <= w_data[CTRL_COUNT_CLEAR_BIT];
					end
				end else if (aw_addr == STATUS_OFFSET || aw_addr == COUNTS_OFFSET) begin
					s_axi_bresp <= RESP_OKAY; // Read-only words ignore writes.
				end else begin
					s_axi_bresp <= RESP_SLVERR;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read path: one cycle from address to data.
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				CONTROL_OFFSET: s_axi_rdata <= {30'h0, hold_enable};
				STATUS_OFFSET: s_axi_rdata <= {12'h0, latch_hold, enable_level, thermal_trip,
					armed, driver_on_o, fire_command};
				COUNTS_OFFSET: s_axi_rdata <= {counts[3], counts[2], counts[1], counts[0]};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : squib_arm_fire_sequencer

// ### bench/squib_seq_sva.sv
`timescale 1ns/1ps
// Port checker for the sequencer; helper counters track steady pin levels.
module squib_seq_sva (
	// Clock, reset and command strobe.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_byte_i,
	input wire logic [7:0] echo_byte_o,
	input wire logic diag_clear_o,
	// Pins and drivers.
	input wire logic fire_enable_pin_one_i,
	input wire logic fire_enable_pin_two_i,
	input wire logic [3:0] thermal_shutdown_i,
	input wire logic [3:0] driver_on_o,
	// Read channel.
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid
);
	logic [3:0] high_cnt; // Cycles with both pins high.
	logic [3:0] low_two_cnt; // Cycles with pin two low.
	// Pins pass a synchroniser, so only a level held for many cycles is trusted.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			high_cnt <= 4'h0;
			low_two_cnt <= 4'h0;
		end else begin
			high_cnt <= !(fire_enable_pin_one_i && fire_enable_pin_two_i) ? 4'h0 :
				(high_cnt == 4'hf ? 4'hf : high_cnt + 4'h1);
			low_two_cnt <= fire_enable_pin_two_i ? 4'h0 :
				(low_two_cnt == 4'hf ? 4'hf : low_two_cnt + 4'h1);
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_fire_apply: assert property (cmd_valid_i && cmd_byte_i == 8'ha2 ##1 cmd_valid_i &&
		cmd_byte_i[7:4] == 4'h5 && high_cnt == 4'hf && thermal_shutdown_i == 4'h0
		|-> ##3 driver_on_o == $past(cmd_byte_i[3:0], 3)) else $error("fire byte not applied");
	chk_bad_parity: assert property (cmd_valid_i && cmd_byte_i[7:4] == 4'ha ##1 cmd_valid_i &&
		cmd_byte_i[7:4] != 4'h5 && high_cnt == 4'hf && thermal_shutdown_i == 4'h0
		|-> ##3 $stable(driver_on_o) [*4]) else $error("mismatched byte changed drivers");
	chk_no_arm_nop: assert property (cmd_valid_i && cmd_byte_i[7:4] != 4'ha &&
		cmd_byte_i[7:4] != 4'h5 ##1 cmd_valid_i && cmd_byte_i[7:4] == 4'h5 && high_cnt == 4'hf
		|-> ##3 $stable(driver_on_o) [*4]) else $error("unarmed fire byte acted");
	chk_echo_cmd: assert property (cmd_valid_i && (cmd_byte_i inside {8'ha0, 8'ha1, 8'ha2} ||
		cmd_byte_i[7:4] == 4'h5) |=> echo_byte_o == $past(cmd_byte_i)) else $error("echo wrong");
	chk_echo_zero: assert property (cmd_valid_i && !(cmd_byte_i inside {8'ha0, 8'ha1, 8'ha2}) &&
		cmd_byte_i[7:4] != 4'h5 |=> echo_byte_o == 8'h00) else $error("echo not zero");
	chk_diag_pulse: assert property (cmd_valid_i && cmd_byte_i == 8'ha2 && high_cnt == 4'hf
		|=> diag_clear_o) else $error("no diagnostic clear after arm");
	chk_two_gate: assert property (low_two_cnt == 4'hf |-> driver_on_o[3:2] == 2'b00)
		else $error("group two on with its enable low");
	chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && // AXI
		s_axi_rresp == ($past(s_axi_araddr) inside {4'h0, 4'h4, 4'h8} ? 2'h0 : 2'h2))
		else $error("read answer wrong");
	chk_reset_idle: assert property ($fell(rst_i) |-> driver_on_o == 4'h0 &&
		echo_byte_o == 8'h00) else $error("state not idle after reset");
endmodule : squib_seq_sva

bind squib_arm_fire_sequencer squib_seq_sva u_squib_seq_sva (.clk_i, .rst_i, .cmd_valid_i,
	.cmd_byte_i, .echo_byte_o, .diag_clear_o, .fire_enable_pin_one_i, .fire_enable_pin_two_i,
	.thermal_shutdown_i, .driver_on_o, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rresp, .s_axi_rvalid);

// ### bench/squib_host_model.sv
`timescale 1ns/1ps
// Host side of the command link: each byte arrives as a one-cycle strobe.
module squib_host_model (
	// Clock.
	input wire logic clk_i,
	// Byte strobe towards the sequencer.
	output logic cmd_valid_o,
	output logic [7:0] cmd_byte_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_byte_o = 8'h00;
	end
	// Back-to-back calls give consecutive strobes; a fire byte needs only to be the next byte.
	task put_byte(input logic [7:0] b);
		@(posedge clk_i);
		cmd_valid_o <= 1'b1;
		cmd_byte_o <= b;
	endtask : put_byte
	// A quiet link shows the inverse of the last byte, so stale data never looks valid.
	task idle();
		@(posedge clk_i);
		cmd_valid_o <= 1'b0;
		cmd_byte_o <= ~cmd_byte_o;
	endtask : idle
endmodule : squib_host_model

// ### bench/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the arm-then-fire sequencer.
module tb;
	import squib_pkg::*;
	// Command row: two bytes, pin levels, expected drivers and echo.
	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
		logic [1:0] pins;
		logic [3:0] drv;
		logic [7:0] echo;
	} row_type;
	row_type rows [9];
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cmd_valid_i, diag_clear_o;
	logic [7:0] cmd_byte_i, echo_byte_o;
	logic fire_enable_pin_one_i = 1'b1;
	logic fire_enable_pin_two_i = 1'b1;
	logic [3:0] thermal_shutdown_i = 4'h0;
	logic [3:0] current_measure_threshold_i = 4'h0;
	logic [3:0] driver_on_o, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
	int compares = 0, miscompares = 0, cycles = 0;
	always #5 clk_i = ~clk_i;
	// Short timer values keep the run brief.
	squib_arm_fire_sequencer #(.MIN_FIRE_CYCLES(20), .MEAS_WINDOW_CYCLES(40))
	u_squib_arm_fire_sequencer (.clk_i, .rst_i, .cmd_valid_i, .cmd_byte_i, .echo_byte_o,
		.diag_clear_o, .fire_enable_pin_one_i, .fire_enable_pin_two_i, .thermal_shutdown_i,
		.current_measure_threshold_i, .driver_on_o, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	squib_host_model u_squib_host_model (.clk_i, .cmd_valid_o(cmd_valid_i), .cmd_byte_o(cmd_byte_i));
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	// Handshakes are judged mid-cycle, which equals their value at the next edge.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		bh = 1'b0;
		while (!bh) begin
			@(negedge clk_i);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid;
			wr_resp = s_axi_bresp;
			@(posedge clk_i);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		logic ah, rh;
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		rh = 1'b0;
		while (!rh) begin
			@(negedge clk_i);
			ah = s_axi_arvalid && s_axi_arready;
			rh = s_axi_rvalid;
			rd_data = s_axi_rdata;
			rd_resp = s_axi_rresp;
			@(posedge clk_i);
			if (ah) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask : rd
	// Arm and fire bytes go out back to back, then the drivers get time to follow.
	task pair(input logic [7:0] a, input logic [7:0] f);
		u_squib_host_model.put_byte(a);
		u_squib_host_model.put_byte(f);
		u_squib_host_model.idle();
		repeat (6) @(posedge clk_i);
	endtask : pair
	// Pin changes pass a synchroniser, so each is given time to settle.
	task set_pins(input logic [1:0] p);
		@(posedge clk_i);
		fire_enable_pin_one_i <= p[0];
		fire_enable_pin_two_i <= p[1];
		repeat (20) @(posedge clk_i);
	endtask : set_pins
	// A hang counts as a mismatch and ends the run through the report.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		rows = '{'{8'ha2, 8'h5f, 2'h3, 4'hf, 8'h5f}, '{8'ha2, 8'h50, 2'h3, 4'h0, 8'h50},
			'{8'ha0, 8'h53, 2'h3, 4'h3, 8'h53}, '{8'ha1, 8'h5c, 2'h3, 4'hf, 8'h5c},
			'{8'ha0, 8'h50, 2'h3, 4'hc, 8'h50}, '{8'ha2, 8'h6f, 2'h3, 4'hc, 8'h00},
			'{8'h00, 8'h5f, 2'h3, 4'hc, 8'h5f}, '{8'ha2, 8'h5a, 2'h3, 4'ha, 8'h5a},
			'{8'ha1, 8'h51, 2'h1, 4'h2, 8'h51}};
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		for (int i = 0; i < 9; i++) begin
			set_pins(rows[i].pins);
			pair(rows[i].first, rows[i].second);
			check("drivers", {28'h0, rows[i].drv}, {28'h0, driver_on_o});
			check("echo", {24'h0, rows[i].echo}, {24'h0, echo_byte_o});
		end
		$display("test rows done");
		set_pins(2'h3);
		check("resume", 32'ha, {28'h0, driver_on_o});
		wr(CONTROL_OFFSET, 32'h1);
		check("wr_resp", {30'h0, RESP_OKAY}, {30'h0, wr_resp});
		rd(CONTROL_OFFSET);
		check("control_rd", 32'h1, rd_data);
		pair(8'ha2, 8'h5f);
		set_pins(2'h2);
		check("held", 32'hf, {28'h0, driver_on_o});
		rd(STATUS_OFFSET);
		check("status", 32'h6, {28'h0, rd_data[19:16]});
		check("status_low", 32'hff, {16'h0, rd_data[15:0]});
		set_pins(2'h3);
		wr(CONTROL_OFFSET, 32'h0);
		pair(8'ha2, 8'h50);
		check("all_off", 32'h0, {28'h0, driver_on_o});
		$display("test hold done");
		@(posedge clk_i);
		thermal_shutdown_i <= 4'h1;
		pair(8'ha2, 8'h5f);
		check("thermal_early", 32'hf, {28'h0, driver_on_o});
		repeat (40) @(posedge clk_i);
		check("thermal_late", 32'he, {28'h0, driver_on_o});
		thermal_shutdown_i <= 4'h0;
		current_measure_threshold_i <= 4'hf;
		repeat (10) @(posedge clk_i);
		pair(8'ha2, 8'h5f);
		check("refire", 32'hf, {28'h0, driver_on_o});
		repeat (100) @(posedge clk_i);
		rd(COUNTS_OFFSET);
		check("count_window", 32'h28, {24'h0, rd_data[7:0]});
		check("count_lanes", {4{rd_data[7:0]}}, rd_data);
		current_measure_threshold_i <= 4'h0;
		wr(CONTROL_OFFSET, 32'h4);
		rd(COUNTS_OFFSET);
		check("count_clear", 32'h0, rd_data);
		rd(4'hc);
		check("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, rd_resp});
		check("unmapped_data", 32'h0, rd_data);
		wr(4'hc, 32'h0);
		check("unmapped_wr", {30'h0, RESP_SLVERR}, {30'h0, wr_resp});
		$display("test counters done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		check("reset_drivers", 32'h0, {28'h0, driver_on_o});
		check("reset_echo", 32'h0, {24'h0, echo_byte_o});
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		u_squib_host_model.put_byte(8'h5f);
		u_squib_host_model.idle();
		repeat (6) @(posedge clk_i);
		check("no_arm_fire", 32'h0, {28'h0, driver_on_o});
		$display("test reset done");
		summarize();
	end
endmodule : tb
